// ---- shared/coc_pkg.sv ----
package coc_pkg;
	localparam int NCH      = 8;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 32;
	// Word addresses of the register file
	localparam logic [3:0] ADDR_CH0    = 4'h0;
	localparam logic [3:0] ADDR_BOOST  = 4'h9;
	localparam logic [3:0] ADDR_PROBE  = 4'hd;
	localparam logic [3:0] ADDR_DEVCTL = 4'he;
	localparam logic [3:0] ADDR_STATUS = 4'hf;
	// Channel register fields
	localparam int SOFT_RST_BIT = 31;
	localparam int PATH_HI      = 18;
	localparam int PATH_LO      = 17;
	localparam int ON_BIT       = 16;
	localparam int DIV_HI       = 15;
	localparam int DIV_LO       = 8;
	localparam int DLY_HI       = 7;
	localparam int DLY_LO       = 4;
	// Boost, device control and probe fields
	localparam int BOOST_BIT    = 16;
	localparam int CHOICE_BIT   = 29;
	localparam int ALL_ON_BIT   = 27;
	localparam int SHUTDOWN_BIT = 26;
	localparam int PROBE_W      = 3;
	// Reset values
	localparam logic [7:0]  DIV_RST    = 8'h01;
	localparam logic [3:0]  DLY_RST    = 4'h0;
	localparam logic [31:0] BOOST_RST  = 32'h00022a00;
	localparam logic [31:0] DEVCTL_RST = 32'h48000000;
	// Synchroniser order {align, gate, ref_b, ref_a}
	localparam logic [3:0]  SYNC_RST   = 4'hc;
	localparam int S_REF_A = 0;
	localparam int S_REF_B = 1;
	localparam int S_GATE  = 2;
	localparam int S_ALIGN = 3;
	// Path latencies of the analog stages, in ps
	localparam int LAT_W          = 12;
	localparam int DIV_STAGE_PS   = 100;
	localparam int DLY_STAGE_PS   = 400;
	localparam int DLY_STEP_PS    = 150;
	typedef enum logic [1:0] {
		PATH_BYPASS  = 2'h0,
		PATH_DIVIDED = 2'h1,
		PATH_DELAYED = 2'h2,
		PATH_DIV_DLY = 2'h3
	} coc_path_type;
endpackage

// ---- rtl/coc_clock_output_ctrl.sv ----
`timescale 1ns/100ps
// Behaviour
// - Divider acts only in divided or divided-and-delayed path modes.
// - Divide ratio is twice the 8-bit code; code zero is invalid.
// - Divider stage adds about 100 ps latency versus bypass.
// - Delay code acts only in delayed or divided-and-delayed modes.
// - Delay code adds 150 ps per step, 0 to 2250 ps.
// - Delay stage adds about 400 ps on top of coded delay.
// - A channel drives its clock only while its enable bit is set.
// - Gate pin low or global enable zero disables every channel.
// - An unconnected gate pin counts as high.
// - Boost bit puts all channels into raised swing together.
// - Shutdown bit powers everything down regardless of other settings.
// - Global enable overrides channel enables; one is normal, default.
// - Input choice zero selects second reference, one the first.
// - Path select: 0 bypass, 1 divided, 2 delayed, 3 both.
// - Channel fields at 18:17, 16, 15:8, 7:4; divide resets to one.
// - Bit 31 write to channel 0 restores all power-on values.
module coc_clock_output_ctrl #(
	parameter int NCH = coc_pkg::NCH
) (
	input  wire logic             sys_clk_in,     // System clock
	input  wire logic             sys_rst_in,     // Sync reset, high
	input  wire logic [3:0]       addr_in,        // Register address
	input  wire logic [31:0]      wr_data_in,     // Write data
	input  wire logic             wr_in,          // Write strobe
	input  wire logic             rd_in,          // Read strobe
	input  wire logic             ref_input_a_in, // First reference
	input  wire logic             ref_input_b_in, // Second reference
	input  wire logic             output_gate_pin_in, // Gate pin
	input  wire logic             align_n_in,     // Align pin, low
	output logic [31:0]           rd_data_out,    // Read data
	output logic [NCH-1:0]        chan_clk_out,   // Channel clocks
	output logic                  boost_out,      // Raised swing
	output logic                  shutdown_out    // Powered down
);

	logic [3:0]          sync1_ff;
	logic [3:0]          sync2_ff;
	logic                ref_prev_ff;
	logic [1:0]          path_ff [NCH];
	logic [NCH-1:0]      on_ff;
	logic [7:0]          div_ff [NCH];
	logic [3:0]          dly_ff [NCH];
	logic [31:0]         boost_ff;
	logic [31:0]         devctl_ff;
	logic [2:0]          probe_ff;
	logic [7:0]          cnt_ff [NCH];
	logic [NCH-1:0]      div_q_ff;
	logic [31:0]         nxt_rd_data;
	logic [NCH-1:0]      nxt_chan_clk;
	logic                ref_sel;
	logic                ref_edge;
	logic                soft_rst;
	logic                all_off;
	logic                shut;

	function automatic logic has_div(input logic [1:0] p);
		has_div = (p == coc_pkg::PATH_DIVIDED) ||
			(p == coc_pkg::PATH_DIV_DLY);
	endfunction

	function automatic logic has_dly(input logic [1:0] p);
		has_dly = (p == coc_pkg::PATH_DELAYED) ||
			(p == coc_pkg::PATH_DIV_DLY);
	endfunction

	// Modelled path latency of one channel in ps
	function automatic logic [11:0] lat_ps(
		input logic [1:0] p,
		input logic [3:0] d
	);
		logic [11:0] l;
		l = 12'h000;
		if (has_div(p)) begin
			l = l + 12'(coc_pkg::DIV_STAGE_PS);
		end
		if (has_dly(p)) begin
			l = l + 12'(coc_pkg::DLY_STAGE_PS)
				+ 12'(coc_pkg::DLY_STEP_PS) * 12'(d);
		end
		lat_ps = l;
	endfunction

	// Pins pass two flops; gate resets high as an open pin does
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sync1_ff <= coc_pkg::SYNC_RST;
			sync2_ff <= coc_pkg::SYNC_RST;
		end else begin
			sync1_ff <= {align_n_in, output_gate_pin_in,
				ref_input_b_in, ref_input_a_in};
			sync2_ff <= sync1_ff;
		end
	end

	assign shut    = devctl_ff[coc_pkg::SHUTDOWN_BIT];
	assign ref_sel = devctl_ff[coc_pkg::CHOICE_BIT] ?
		sync2_ff[coc_pkg::S_REF_A] : sync2_ff[coc_pkg::S_REF_B];
	assign ref_edge = ref_sel & ~ref_prev_ff;
	assign all_off  = ~sync2_ff[coc_pkg::S_GATE] |
		~devctl_ff[coc_pkg::ALL_ON_BIT] | shut;
	assign soft_rst = wr_in && (addr_in == coc_pkg::ADDR_CH0) &&
		wr_data_in[coc_pkg::SOFT_RST_BIT];

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ref_prev_ff <= 1'b0;
		end else begin
			ref_prev_ff <= ref_sel;
		end
	end

	// Register file
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || soft_rst) begin
			for (int i = 0; i < NCH; i++) begin
				path_ff[i] <= coc_pkg::PATH_BYPASS;
				on_ff[i]   <= 1'b0;
				div_ff[i]  <= coc_pkg::DIV_RST;
				dly_ff[i]  <= coc_pkg::DLY_RST;
			end
			boost_ff  <= coc_pkg::BOOST_RST;
			devctl_ff <= coc_pkg::DEVCTL_RST;
			probe_ff  <= 3'h0;
		end else if (wr_in) begin
			for (int i = 0; i < NCH; i++) begin
				if (addr_in == 4'(i)) begin
					path_ff[i] <= wr_data_in[coc_pkg::PATH_HI:
						coc_pkg::PATH_LO];
					on_ff[i]   <= wr_data_in[coc_pkg::ON_BIT];
					div_ff[i]  <= wr_data_in[coc_pkg::DIV_HI:
						coc_pkg::DIV_LO];
					dly_ff[i]  <= wr_data_in[coc_pkg::DLY_HI:
						coc_pkg::DLY_LO];
				end
			end
			case (addr_in)
				coc_pkg::ADDR_BOOST: begin
					boost_ff <= wr_data_in;
				end
				coc_pkg::ADDR_DEVCTL: begin
					devctl_ff <= wr_data_in;
				end
				coc_pkg::ADDR_PROBE: begin
					probe_ff <= wr_data_in[coc_pkg::PROBE_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_comb begin
		nxt_rd_data = 32'h0;
		for (int i = 0; i < NCH; i++) begin
			if (addr_in == 4'(i)) begin
				nxt_rd_data[coc_pkg::PATH_HI:coc_pkg::PATH_LO] =
					path_ff[i];
				nxt_rd_data[coc_pkg::ON_BIT] = on_ff[i];
				nxt_rd_data[coc_pkg::DIV_HI:coc_pkg::DIV_LO] =
					div_ff[i];
				nxt_rd_data[coc_pkg::DLY_HI:coc_pkg::DLY_LO] =
					dly_ff[i];
			end
		end
		case (addr_in)
			coc_pkg::ADDR_BOOST: begin
				nxt_rd_data = boost_ff;
			end
			coc_pkg::ADDR_DEVCTL: begin
				nxt_rd_data = devctl_ff;
			end
			coc_pkg::ADDR_PROBE: begin
				nxt_rd_data[coc_pkg::LAT_W-1:0] = lat_ps(path_ff[probe_ff],
					dly_ff[probe_ff]);
			end
			coc_pkg::ADDR_STATUS: begin
				nxt_rd_data[NCH-1:0] = chan_clk_out;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rd_data_out <= 32'h0;
		end else begin
			rd_data_out <= rd_in ? nxt_rd_data : 32'h0;
		end
	end

	// Per-channel dividers
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			always_ff @(posedge sys_clk_in) begin
				if (sys_rst_in || shut ||
					!sync2_ff[coc_pkg::S_ALIGN] ||
					!has_div(path_ff[g])) begin
					cnt_ff[g]   <= 8'h00;
					div_q_ff[g] <= 1'b0;
				end else if (ref_edge) begin
					// Code zero treated as one
					if (cnt_ff[g] + 8'h01 >= div_ff[g]) begin
						cnt_ff[g]   <= 8'h00;
						div_q_ff[g] <= ~div_q_ff[g];
					end else begin
						cnt_ff[g] <= cnt_ff[g] + 8'h01;
					end
				end
			end
			always_comb begin
				if (all_off || !on_ff[g]) begin
					nxt_chan_clk[g] = 1'b0;
				end else if (has_div(path_ff[g])) begin
					nxt_chan_clk[g] = div_q_ff[g];
				end else begin
					nxt_chan_clk[g] = ref_sel;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			chan_clk_out <= '0;
			boost_out    <= 1'b0;
			shutdown_out <= 1'b0;
		end else begin
			chan_clk_out <= nxt_chan_clk;
			boost_out    <= boost_ff[coc_pkg::BOOST_BIT] & ~shut;
			shutdown_out <= shut;
		end
	end

	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence soft_wr_s;
		wr_in && addr_in == coc_pkg::ADDR_CH0 &&
			wr_data_in[coc_pkg::SOFT_RST_BIT];
	endsequence

	sequence dev_wr_s;
		wr_in && addr_in == coc_pkg::ADDR_DEVCTL;
	endsequence

	gate_blocks_a: assert property (
		!sync2_ff[coc_pkg::S_GATE] |=> chan_clk_out == '0)
		else $error("gate low but a channel drives");
	global_off_a: assert property (
		dev_wr_s ##0 !wr_data_in[coc_pkg::ALL_ON_BIT]
		|=> ##1 chan_clk_out == '0 [*2])
		else $error("global enable off but a channel drives");
	shutdown_all_a: assert property (
		shut |=> shutdown_out && !boost_out && chan_clk_out == '0)
		else $error("shutdown not honoured");
	chan_off_a: assert property (
		!on_ff[0] |=> !chan_clk_out[0])
		else $error("disabled channel drives");
	bypass_follow_a: assert property (
		!all_off && on_ff[0] && path_ff[0] == coc_pkg::PATH_BYPASS
		|=> chan_clk_out[0] == $past(ref_sel))
		else $error("bypass channel does not follow reference");
	delayed_follow_a: assert property (
		!all_off && on_ff[2] && path_ff[2] == coc_pkg::PATH_DELAYED
		|=> chan_clk_out[2] == $past(ref_sel))
		else $error("delayed channel does not follow reference");
	// Divider checks watch channel 1, the one whose period t_div measures
	div_toggle_a: assert property (
		has_div(path_ff[1]) && div_ff[1] == 8'h01 && ref_edge &&
		!shut && sync2_ff[coc_pkg::S_ALIGN] && !soft_rst
		|=> div_q_ff[1] != $past(div_q_ff[1]))
		else $error("divide by two missed an edge");
	align_hold_a: assert property (
		!sync2_ff[coc_pkg::S_ALIGN] |=> !div_q_ff[1] && cnt_ff[1] == 8'h00)
		else $error("divider not held by align");
	soft_reset_a: assert property (
		soft_wr_s |=> devctl_ff == coc_pkg::DEVCTL_RST &&
		div_ff[0] == coc_pkg::DIV_RST && !on_ff[0])
		else $error("soft reset did not restore defaults");
	boost_mode_a: assert property (
		boost_ff[coc_pkg::BOOST_BIT] && !shut |=> boost_out)
		else $error("boost bit not applied");
	input_pick_a: assert property (
		!devctl_ff[coc_pkg::CHOICE_BIT] |->
		ref_sel == sync2_ff[coc_pkg::S_REF_B])
		else $error("wrong reference selected");
	read_once_a: assert property (
		!rd_in |=> rd_data_out == 32'h0)
		else $error("read data outside its cycle");

endmodule

// ---- verif/coc_host_model.sv ----
`timescale 1ns/100ps
module coc_host_model (
	input  wire logic        sys_clk_in,  // Clock
	input  wire logic [31:0] rd_data_in,  // Read data
	output logic [3:0]       addr_out,    // Address
	output logic [31:0]      wr_data_out, // Write data
	output logic             wr_out,      // Write strobe
	output logic             rd_out,      // Read strobe
	output logic             align_n_out  // Align pin
);
	initial begin
		addr_out = 4'h0;
		wr_data_out = 32'h0;
		wr_out = 1'b0;
		rd_out = 1'b0;
		align_n_out = 1'b1;
	end
	// Fixed bits kept, only the boost bit varies
	function automatic logic [31:0] boost_word(input logic b);
		boost_word = 32'h00022a00;
		boost_word[16] = b;
	endfunction
	function automatic logic [31:0] ctl_word(input logic c, o, s);
		ctl_word = 32'h48000000;
		ctl_word[29] = c;
		ctl_word[27] = o;
		ctl_word[26] = s;
	endfunction
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		wr_data_out <= d;
		wr_out <= 1'b1;
		@(posedge sys_clk_in);
		wr_out <= 1'b0;
		wr_data_out <= ~d;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge sys_clk_in);
		rd_out <= 1'b0;
		#1 d = rd_data_in;
	endtask
	// Pulsed once all divide codes are programmed
	task automatic align(input int n);
		@(posedge sys_clk_in);
		align_n_out <= 1'b0;
		repeat (n) @(posedge sys_clk_in);
		align_n_out <= 1'b1;
	endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	logic        clk, rst, ref_a, ref_b, gate, ref_run, wr, rd, align_n;
	logic        boost, shut;
	logic [1:0]  ref_cnt;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata;
	logic [7:0]  chan;
	int          n_fail, n_checks;
	coc_clock_output_ctrl dut (.sys_clk_in(clk), .sys_rst_in(rst),
		.addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
		.ref_input_a_in(ref_a), .ref_input_b_in(ref_b),
		.output_gate_pin_in(gate), .align_n_in(align_n),
		.rd_data_out(rdata), .chan_clk_out(chan), .boost_out(boost),
		.shutdown_out(shut));
	coc_host_model host (.sys_clk_in(clk), .rd_data_in(rdata),
		.addr_out(addr), .wr_data_out(wdata), .wr_out(wr), .rd_out(rd),
		.align_n_out(align_n));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		ref_cnt <= ref_cnt + 2'h1;
		if (ref_run) begin
			ref_a <= ref_cnt[1];
		end
	end
	task automatic conclude();
		if (n_fail == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] v;
		host.rd_reg(a, v);
		chk(v, exp);
	endtask
	task automatic t_reset();
		rchk(4'h0, 32'h00000100);
		rchk(4'he, 32'h48000000);
		rchk(4'ha, 32'h0);
		chk({boost, shut, chan}, 10'h0);
	endtask
	task automatic t_enable();
		logic [4:0] cf [7] = '{5'h0d, 5'h05, 5'h0c, 5'h09, 5'h1d, 5'h1f, 5'h0d};
		logic [9:0] ex [7] = '{10'h5, 10'h0, 10'h0, 10'h0, 10'h205, 10'h100,
			10'h5};
		ref_a <= 1'b1;
		host.wr_reg(4'h0, 32'h00010100);
		host.wr_reg(4'h2, 32'h00050100);
		foreach (cf[i]) begin
			host.wr_reg(4'h9, host.boost_word(cf[i][4]));
			host.wr_reg(4'he, host.ctl_word(cf[i][3], cf[i][2], cf[i][1]));
			gate <= cf[i][0];
			wt(6);
			chk({boost, shut, chan}, ex[i]);
			rchk(4'hf, {24'h0, ex[i][7:0]});
		end
	endtask
	task automatic t_probe();
		for (int p = 0; p < 4; p++) begin
			for (int d = 0; d < 16; d += 15) begin
				host.wr_reg(4'h3, {13'h0, p[1:0], 1'b0, 8'h01, d[3:0], 4'h0});
				host.wr_reg(4'hd, 32'h3);
				rchk(4'hd, (p[0] ? 100 : 0) + (p[1] ? 400 + 150 * d : 0));
			end
		end
	endtask
	task automatic period(input int exp);
		int n, e, t0;
		logic prev;
		wt(1);
		prev = chan[1];
		e = 0;
		n = 0;
		t0 = 0;
		while (e < 2 && n < 5000) begin
			wt(1);
			n++;
			if (chan[1] === 1'b1 && prev !== 1'b1) begin
				e++;
				if (e == 1) begin
					t0 = n;
				end
			end
			prev = chan[1];
		end
		if (e < 2) begin
			n_fail++;
			conclude();
		end
		chk(n - t0, exp);
	endtask
	task automatic t_div();
		logic [9:0] c [6] = '{10'h003, 10'h103, 10'h203, 10'h303, 10'h101,
			10'h3ff};
		ref_run <= 1'b1;
		foreach (c[i]) begin
			host.wr_reg(4'h1, {13'h0, c[i][9:8], 1'b1, c[i][7:0], 8'h00});
			host.align(3);
			period(c[i][8] ? 8 * c[i][7:0] : 4);
		end
		host.wr_reg(4'h1, 32'h00030300);
		host.wr_reg(4'h2, 32'h00030300);
		fork
			host.align(20);
			begin
				wt(15);
				chk(chan[2:1], 2'h0);
			end
		join
		repeat (30) begin
			wt(1);
			chk(chan[2], chan[1]);
		end
	endtask
	task automatic t_soft();
		host.wr_reg(4'h4, 32'hffffffff);
		rchk(4'h4, 32'h0007fff0);
		host.wr_reg(4'h0, 32'h8007ffff);
		rchk(4'h0, 32'h00000100);
		rchk(4'h4, 32'h00000100);
		rchk(4'he, 32'h48000000);
		wt(6);
		chk(chan, 8'h0);
	endtask
	initial begin
		rst = 1'b1;
		gate = 1'b1;
		ref_a = 1'b0;
		ref_b = 1'b0;
		ref_run = 1'b0;
		ref_cnt = 2'h0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_enable();
		t_probe();
		t_div();
		t_soft();
		conclude();
	end
endmodule
